//--- hdl/stage_route_cfg.svh
// offsets, field positions and reset values of the stage input routing bank
`ifndef STAGE_ROUTE_CFG_SVH
`define STAGE_ROUTE_CFG_SVH

`define NUM_STAGES      12
`define NUM_INPUTS      13
`define LOW_INPUTS      7
`define STAGE_W         4
`define ADDR_W          12
`define IDX_W           10
`define STAGE0_LOW_IDX  10'h080
`define STAGE0_HIGH_IDX 10'h081
`define STAGE1_LOW_IDX  10'h088
`define BANK_END_IDX    10'h0E0
`define STATUS_IDX      10'h07F
`define LOW_SUB         3'h0
`define HIGH_SUB        3'h1
`define LOW_RESET       16'h3FFF
`define HIGH_RESET      16'h3FFF
`define LOW_WRITE_MASK  16'h3FFF
`define LOW_SEL_W       14
`define HIGH_SEL_W      12
`define MTYPE_LSB       12
`define NEG_OFF_BIT     14
`define POS_OFF_BIT     15

`endif

//--- hdl/stage_route_pkg.sv
// types shared by the stage input routing bank
package stage_route_pkg;
  `include "stage_route_cfg.svh"

  typedef enum logic [1:0] {
    SEL_OPEN = 2'b00,
    SEL_NEG  = 2'b01,
    SEL_POS  = 2'b10,
    SEL_BIAS = 2'b11
  } sel_code_t;

  typedef enum logic [1:0] {
    MT_RESERVED = 2'b00,
    MT_SE_POS   = 2'b01,
    MT_SE_NEG   = 2'b10,
    MT_DIFF     = 2'b11
  } mtype_t;

  typedef enum logic [0:0] {
    PH_IDLE = 1'b0,
    PH_RESP = 1'b1
  } apb_phase_t;

  typedef struct packed {
    apb_phase_t                         phase;
    logic [`NUM_STAGES-1:0][15:0]       low;
    logic [`NUM_STAGES-1:0][15:0]       high;
    logic                               pready;
    logic                               pslverr;
    logic [31:0]                        prdata;
    logic [`NUM_INPUTS-1:0]             pos;
    logic [`NUM_INPUTS-1:0]             neg;
    logic [`NUM_INPUTS-1:0]             bias;
    logic [1:0]                         mtype;
    logic                               neg_on;
    logic                               pos_on;
  } bank_state_t;
endpackage : stage_route_pkg

//--- hdl/route_if.sv
// carrier between the register bank and the routing decoder
`timescale 1ns/10ps
`include "stage_route_cfg.svh"
interface route_if;
  logic [15:0]                low_word;
  logic [15:0]                high_word;
  logic [`NUM_INPUTS-1:0]     pos;
  logic [`NUM_INPUTS-1:0]     neg;
  logic [`NUM_INPUTS-1:0]     bias;
  logic [1:0]                 mtype;
  logic                       neg_on;
  logic                       pos_on;

  modport bank    (output low_word, high_word, input pos, neg, bias, mtype, neg_on, pos_on);
  modport decoder (input low_word, high_word, output pos, neg, bias, mtype, neg_on, pos_on);
endinterface : route_if

//--- hdl/stage_route_decode.sv
// decodes one stage's two routing words into per-input switch controls
`timescale 1ns/10ps
`include "stage_route_cfg.svh"
module stage_route_decode (
  route_if.decoder rt
);
  wire [25:0] sels = {rt.high_word[`HIGH_SEL_W-1:0], rt.low_word[`LOW_SEL_W-1:0]};

  genvar i;
  generate
    for (i = 0; i < `NUM_INPUTS; i++) begin : g_in
      assign rt.pos[i]  = (sels[2*i +: 2] == stage_route_pkg::SEL_POS);
      assign rt.neg[i]  = (sels[2*i +: 2] == stage_route_pkg::SEL_NEG);
      assign rt.bias[i] = (sels[2*i +: 2] == stage_route_pkg::SEL_BIAS);
    end
  endgenerate

  // code 00 matches none of the three, so the input stays open
  assign rt.mtype  = rt.high_word[`MTYPE_LSB +: 2];
  assign rt.neg_on = ~rt.high_word[`NEG_OFF_BIT];
  assign rt.pos_on = ~rt.high_word[`POS_OFF_BIT];
endmodule : stage_route_decode

//--- hdl/stage_input_connection_config.sv
// stage input routing register bank with APB access and active-stage switch outputs
`timescale 1ns/10ps
`include "stage_route_cfg.svh"
module stage_input_connection_config (
  input  wire logic                     ref_clk,
  input  wire logic                     sys_rst,
  input  wire logic                     clk_en,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [`ADDR_W-1:0]       paddr,
  input  wire logic [31:0]              pwdata,
  output logic                          pready,
  output logic                          pslverr,
  output logic [31:0]                   prdata,
  input  wire logic [`STAGE_W-1:0]      active_stage,
  output logic [`NUM_INPUTS-1:0]        sense_input_pos,
  output logic [`NUM_INPUTS-1:0]        sense_input_neg,
  output logic [`NUM_INPUTS-1:0]        sense_input_bias,
  output logic [1:0]                    measurement_type_field,
  output logic                          negative_offset_on,
  output logic                          positive_offset_on
);
  stage_route_pkg::bank_state_t st_reg;
  stage_route_pkg::bank_state_t st_next;

  route_if rt ();

  stage_route_decode stage_route_decode_inst (
    .rt (rt.decoder)
  );

  logic [`IDX_W-1:0]   idx;
  logic [`IDX_W-1:0]   rel;
  logic [`STAGE_W-1:0] stg;
  logic [2:0]          sub;
  logic                aligned;
  logic                in_bank;
  logic                is_low;
  logic                is_high;
  logic                is_status;
  logic                hit;
  logic                stage_ok;
  logic [31:0]         rd_data;

  // address decode: the printed offsets are word indices, byte address is four times that
  always_comb begin
    idx       = paddr[`ADDR_W-1:2];
    rel       = idx - `STAGE0_LOW_IDX;
    stg       = rel[6:3];
    sub       = rel[2:0];
    aligned   = (paddr[1:0] == 2'h0);
    in_bank   = aligned && (idx >= `STAGE0_LOW_IDX) && (idx < `BANK_END_IDX);
    is_low    = in_bank && (sub == `LOW_SUB);
    is_high   = in_bank && (sub == `HIGH_SUB);
    is_status = aligned && (idx == `STATUS_IDX);
    hit       = is_low || is_high || is_status;
    stage_ok  = (active_stage < 4'(`NUM_STAGES));
  end

  // read mux; other words of a stage block belong to other blocks and answer with an error
  always_comb begin
    rd_data = 32'h0000_0000;
    if (is_low) begin
      rd_data[15:0] = st_reg.low[stg] & `LOW_WRITE_MASK;
    end else if (is_high) begin
      rd_data[15:0] = st_reg.high[stg];
    end else if (is_status) begin
      rd_data[3:0] = active_stage;
      rd_data[5:4] = st_reg.mtype;
      rd_data[6]   = (st_reg.mtype == stage_route_pkg::MT_RESERVED);
      rd_data[7]   = ~stage_ok;
    end
  end

  // an out-of-range stage leaves every input open rather than guessing a stage
  always_comb begin
    rt.low_word  = stage_ok ? st_reg.low[active_stage]  : 16'h0000;
    rt.high_word = stage_ok ? st_reg.high[active_stage] : 16'h0000;
  end

  always_comb begin
    st_next = st_reg;
    if (clk_en) begin
      st_next.pos    = rt.pos;
      st_next.neg    = rt.neg;
      st_next.bias   = rt.bias;
      st_next.mtype  = rt.mtype;
      st_next.neg_on = rt.neg_on;
      st_next.pos_on = rt.pos_on;
      case (st_reg.phase)
        stage_route_pkg::PH_IDLE: begin
          if (psel && penable) begin
            st_next.phase   = stage_route_pkg::PH_RESP;
            st_next.pready  = 1'b1;
            st_next.pslverr = ~hit;
            st_next.prdata  = rd_data;
          end
        end
        stage_route_pkg::PH_RESP: begin
          st_next.phase   = stage_route_pkg::PH_IDLE;
          st_next.pready  = 1'b0;
          st_next.pslverr = 1'b0;
          // the write lands on the edge that completes the transfer
          if (psel && penable && pwrite) begin
            if (is_low) begin
              st_next.low[stg] = pwdata[15:0] & `LOW_WRITE_MASK;
            end else if (is_high) begin
              st_next.high[stg] = pwdata[15:0];
            end
          end
        end
        default: begin
          st_next.phase = stage_route_pkg::PH_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_reg        <= '0;
      st_reg.phase  <= stage_route_pkg::PH_IDLE;
      st_reg.low    <= {`NUM_STAGES{`LOW_RESET}};
      st_reg.high   <= {`NUM_STAGES{`HIGH_RESET}};
    end else begin
      st_reg <= st_next;
    end
  end

  assign pready                 = st_reg.pready;
  assign pslverr                = st_reg.pslverr;
  assign prdata                 = st_reg.prdata;
  assign sense_input_pos        = st_reg.pos;
  assign sense_input_neg        = st_reg.neg;
  assign sense_input_bias       = st_reg.bias;
  assign measurement_type_field = st_reg.mtype;
  assign negative_offset_on     = st_reg.neg_on;
  assign positive_offset_on     = st_reg.pos_on;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  property p_low_store;
    clk_en && pready && psel && penable && pwrite && is_low
      |=> ((st_reg.low[$past(stg)] & 16'hC000) == 16'h0000);
  endproperty
  a_low_store: assert property (p_low_store) else $error("low word kept upper bits");

  property p_open;
    clk_en && (rt.low_word[1:0] == 2'b00)
      |=> !sense_input_pos[0] && !sense_input_neg[0] && !sense_input_bias[0];
  endproperty
  a_open: assert property (p_open) else $error("open input still switched");

  property p_neg;
    clk_en && (rt.low_word[1:0] == 2'b01) |=> sense_input_neg[0] && !sense_input_pos[0];
  endproperty
  a_neg: assert property (p_neg) else $error("input not on negative side");

  property p_pos;
    clk_en && (rt.high_word[1:0] == 2'b10) |=> sense_input_pos[7] && !sense_input_neg[7];
  endproperty
  a_pos: assert property (p_pos) else $error("input not on positive side");

  property p_bias;
    clk_en && (rt.high_word[11:10] == 2'b11) |=> sense_input_bias[12] && !sense_input_pos[12];
  endproperty
  a_bias: assert property (p_bias) else $error("input not tied to bias");

  property p_high_map;
    clk_en && pready && psel && penable && pwrite && (paddr == {`STAGE0_HIGH_IDX, 2'b00})
      |=> st_reg.high[0] == $past(pwdata[15:0]);
  endproperty
  a_high_map: assert property (p_high_map) else $error("stage 0 upper word not stored");

  property p_diff;
    clk_en && (rt.high_word[13:12] == 2'b11) |=> measurement_type_field == 2'b11;
  endproperty
  a_diff: assert property (p_diff) else $error("differential type not driven");

  property p_neg_off;
    clk_en && rt.high_word[14] |=> !negative_offset_on;
  endproperty
  a_neg_off: assert property (p_neg_off) else $error("negative offset not disabled");

  property p_pos_off;
    clk_en && !rt.high_word[15] |=> positive_offset_on;
  endproperty
  a_pos_off: assert property (p_pos_off) else $error("positive offset not enabled");

  property p_low_read;
    pready && psel && penable && !pwrite && is_low |-> prdata[31:14] == 18'h00000;
  endproperty
  a_low_read: assert property (p_low_read) else $error("low word upper bits not zero");

  property p_stage0_map;
    clk_en && pready && psel && penable && pwrite && (paddr == {`STAGE0_LOW_IDX, 2'b00})
      |=> st_reg.low[0] == ($past(pwdata[15:0]) & `LOW_WRITE_MASK);
  endproperty
  a_stage0_map: assert property (p_stage0_map) else $error("stage 0 lower word misplaced");

  property p_stage1_map;
    clk_en && pready && psel && penable && pwrite && (paddr == {`STAGE1_LOW_IDX, 2'b00})
      |=> st_reg.low[1] == ($past(pwdata[15:0]) & `LOW_WRITE_MASK);
  endproperty
  a_stage1_map: assert property (p_stage1_map) else $error("stage 1 lower word misplaced");

  property p_ready_pulse;
    clk_en && pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready held over two cycles");

  property p_open_high;
    clk_en && (rt.high_word[7:6] == 2'b00)
      |=> !sense_input_pos[10] && !sense_input_neg[10] && !sense_input_bias[10];
  endproperty
  a_open_high: assert property (p_open_high) else $error("input 10 still switched");

  // a stage number past the last one must never close a switch
  property p_range_open;
    clk_en && !stage_ok
      |=> (sense_input_pos == 13'h0000) && (sense_input_neg == 13'h0000)
          && (sense_input_bias == 13'h0000);
  endproperty
  a_range_open: assert property (p_range_open) else $error("bad stage not open");

  property p_pos_top;
    clk_en && (rt.low_word[13:12] == 2'b10) |=> sense_input_pos[6] && !sense_input_bias[6];
  endproperty
  a_pos_top: assert property (p_pos_top) else $error("input 6 not on positive side");

  property p_high_read;
    pready && psel && penable && !pwrite && is_high |-> prdata[31:16] == 16'h0000;
  endproperty
  a_high_read: assert property (p_high_read) else $error("upper word read above bit 15");

  property p_neg_on;
    clk_en && !rt.high_word[14] |=> negative_offset_on;
  endproperty
  a_neg_on: assert property (p_neg_on) else $error("negative offset not enabled");

  property p_pos_dis;
    clk_en && rt.high_word[15] |=> !positive_offset_on;
  endproperty
  a_pos_dis: assert property (p_pos_dis) else $error("positive offset not disabled");

  // a refused write must leave every routing word as it was
  property p_err_keep;
    clk_en && pready && psel && penable && pwrite && !(is_low || is_high)
      |=> $stable(st_reg.low) && $stable(st_reg.high);
  endproperty
  a_err_keep: assert property (p_err_keep) else $error("refused write changed a word");

  property p_err_data;
    pready && pslverr |-> prdata == 32'h0000_0000;
  endproperty
  a_err_data: assert property (p_err_data) else $error("error answer carried data");

  // exactly one wait state: the answer follows the first access edge
  property p_answer;
    clk_en && psel && penable && (st_reg.phase == stage_route_pkg::PH_IDLE) |=> pready;
  endproperty
  a_answer: assert property (p_answer) else $error("access not answered next cycle");

  // with the enable low nothing moves, so a stalled bus keeps its answer
  property p_freeze;
    !clk_en |=> $stable(st_reg);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while enable low");

  property p_cov_write;
    pready && pwrite && is_high;
  endproperty
  c_cov_write: cover property (p_cov_write);

  property p_cov_read;
    pready && !pwrite && is_low;
  endproperty
  c_cov_read: cover property (p_cov_read);

  property p_cov_err;
    pready && pslverr;
  endproperty
  c_cov_err: cover property (p_cov_err);

  property p_cov_freeze;
    !clk_en;
  endproperty
  c_cov_freeze: cover property (p_cov_freeze);

  property p_cov_range;
    clk_en && !stage_ok;
  endproperty
  c_cov_range: cover property (p_cov_range);
endmodule : stage_input_connection_config

//--- test/testbench.sv
// self-checking bench for the stage input routing register bank
`timescale 1ns/10ps
`include "stage_route_cfg.svh"
module testbench;
  logic                    ref_clk;
  logic                    sys_rst;
  logic                    clk_en;
  logic                    psel;
  logic                    penable;
  logic                    pwrite;
  logic [11:0]             paddr;
  logic [31:0]             pwdata;
  logic                    pready;
  logic                    pslverr;
  logic [31:0]             prdata;
  logic [3:0]              active_stage;
  logic [12:0]             sense_input_pos;
  logic [12:0]             sense_input_neg;
  logic [12:0]             sense_input_bias;
  logic [1:0]              measurement_type_field;
  logic                    negative_offset_on;
  logic                    positive_offset_on;
  logic [31:0]             rd;
  logic                    er;
  int                      miscompares;
  int                      comparisons;

  stage_input_connection_config stage_input_connection_config_inst (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .active_stage(active_stage), .sense_input_pos(sense_input_pos),
    .sense_input_neg(sense_input_neg), .sense_input_bias(sense_input_bias),
    .measurement_type_field(measurement_type_field),
    .negative_offset_on(negative_offset_on), .positive_offset_on(positive_offset_on));

  always #20 ref_clk = ~ref_clk;

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk

  // one edge of idle first, so psel is never assigned twice in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // no cycle count is assumed, only the watchdog ends a wait that is never answered
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr_rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] e);
    apb(1'b1, a, d);
    chk(er, 0);
    apb(1'b0, a, 32'h0);
    chk(er, 0);
    chk(rd, e);
  endtask : wr_rd

  task automatic rd_err(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
    chk(er, 1);
    chk(rd, 0);
  endtask : rd_err

  // routing outputs lag active_stage and register writes by one edge
  task automatic route(input logic [3:0] s, input logic [12:0] p, input logic [12:0] n,
                       input logic [12:0] b, input logic [1:0] m, input logic [1:0] o);
    active_stage <= s;
    repeat (3) @(posedge ref_clk);
    chk(sense_input_pos, p);
    chk(sense_input_neg, n);
    chk(sense_input_bias, b);
    chk(measurement_type_field, m);
    chk({negative_offset_on, positive_offset_on}, o);
  endtask : route

  // enable low must hold the pos, neg and bias switch outputs although the selected stage changes
  task automatic freeze;
    clk_en       <= 1'b0;
    active_stage <= 4'h0;
    repeat (3) @(posedge ref_clk);
    chk(sense_input_pos, 13'h0900);
    chk(sense_input_neg, 13'h1200);
    chk(sense_input_bias, 13'h0080);
    clk_en       <= 1'b1;
  endtask : freeze

  task automatic end_of_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (5000) @(posedge ref_clk);
    miscompares++;
    end_of_test();
  end

  initial begin
    ref_clk = 1'b0;
    sys_rst = 1'b1;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    active_stage = 4'h0;
    miscompares = 0;
    comparisons = 0;
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    route(4'h0, 13'h0000, 13'h0000, 13'h1FFF, 2'b11, 2'b11);
    apb(1'b0, 12'h200, 32'h0);
    chk(rd, 32'h3FFF);
    apb(1'b0, 12'h204, 32'h0);
    chk(rd, 32'h3FFF);
    wr_rd(12'h220, 32'h1555, 32'h1555);
    // stage 0: inputs 0..6 positive, 7..12 negative
    wr_rd(12'h200, 32'h2AAA, 32'h2AAA);
    wr_rd(12'h204, 32'h3555, 32'h3555);
    route(4'h0, 13'h007F, 13'h1F80, 13'h0000, 2'b11, 2'b11);
    wr_rd(12'h360, 32'h3FFF, 32'h3FFF);
    wr_rd(12'h364, 32'h3ABC, 32'h3ABC);
    // selector codes 00 01 10 11 in both words of stage 2
    wr_rd(12'h240, 32'h09E4, 32'h09E4);
    wr_rd(12'h244, 32'h761B, 32'h761B);
    route(4'h2, 13'h0924, 13'h1212, 13'h0088, 2'b11, 2'b01);
    route(4'h1, 13'h0000, 13'h007F, 13'h1F80, 2'b11, 2'b11);
    // single-ended stage 3: only input 0 measured, every other input on bias
    wr_rd(12'h260, 32'h3FFE, 32'h3FFE);
    wr_rd(12'h264, 32'h1FFF, 32'h1FFF);
    route(4'h3, 13'h0001, 13'h0000, 13'h1FFE, 2'b01, 2'b11);
    wr_rd(12'h260, 32'h3FFD, 32'h3FFD);
    wr_rd(12'h264, 32'h2FFF, 32'h2FFF);
    route(4'h3, 13'h0000, 13'h0001, 13'h1FFE, 2'b10, 2'b11);
    // type stays differential while both offset controls step through all four codes
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, 12'h244, {16'h0, m[1:0], 2'b11, 12'h61B});
      route(4'h2, 13'h0924, 13'h1212, 13'h0088, 2'b11, {~m[0], ~m[1]});
    end
    route(4'h2, 13'h0924, 13'h1212, 13'h0088, 2'b11, 2'b00);
    rd_err(12'h208);
    rd_err(12'h202);
    rd_err(12'h380);
    apb(1'b1, 12'h208, 32'h1111);
    chk(er, 1);
    wr_rd(12'h240, 32'h0000, 32'h0000);
    route(4'h2, 13'h0900, 13'h1200, 13'h0080, 2'b11, 2'b00);
    freeze();
    route(4'h0, 13'h007F, 13'h1F80, 13'h0000, 2'b11, 2'b11);
    route(4'hC, 13'h0000, 13'h0000, 13'h0000, 2'b00, 2'b11);
    apb(1'b0, 12'h1FC, 32'h0);
    chk(er, 0);
    chk(rd, 32'h0000_00CC);
    end_of_test();
  end
endmodule : testbench
